// File: serial_switch_defs.svh
`ifndef SERIAL_SWITCH_DEFS_SVH
`define SERIAL_SWITCH_DEFS_SVH

// system clock rate and spike suppression window
`define SSM_CLOCK_MHZ 50
`define SSM_SPIKE_NS 50
// samples a new level must stand before it is believed; a pulse just
// under the window can still cover one sample fewer than this
`define SSM_SPIKE_CYCLES ((`SSM_SPIKE_NS * `SSM_CLOCK_MHZ - 1) / 1000 + 2)
// fastest serial clock the link must follow
`define SSM_MAX_KBPS 400

// address byte layout
`define SSM_ADDR_MSB 7
`define SSM_ADDR_LSB 1
`define SSM_RW_BIT 0
`define SSM_STRAP1_BIT 1
`define SSM_STRAP0_BIT 0

// fixed upper address bits per variant
`define SSM_UPPER_EIGHT 5'h13
`define SSM_UPPER_DUAL 5'h11

// control word reset value and width
`define SSM_CTRL_RESET 8'h00
`define SSM_CTRL_BITS 8
`define SSM_LAST_BIT 3'h7

`endif

// File: serial_switch_pkg.sv
package serial_switch_pkg;

   // protocol states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE      = 7'b0000001,
      ST_ADDR      = 7'b0000010,
      ST_ADDR_ACK  = 7'b0000100,
      ST_WRITE     = 7'b0001000,
      ST_WRITE_ACK = 7'b0010000,
      ST_READ      = 7'b0100000,
      ST_READ_ACK  = 7'b1000000
   } state_t;

   // filtered levels of the two bus lines
   typedef struct packed {
      logic scl;
      logic sda;
   } bus_level_t;

   // open-drain drive of the data line
   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_t;

endpackage : serial_switch_pkg

// File: glitch_filter.sv
`timescale 1ns/10ps
`default_nettype none
`include "serial_switch_defs.svh"

module glitch_filter #(
   parameter int unsigned STABLE = `SSM_SPIKE_CYCLES,
   parameter bit IDLE_LEVEL = 1'b1
) (
   // clocking
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   // raw pin and believed level
   input wire logic raw,
   output logic level
);

   localparam int CW = $clog2(STABLE + 1);

   logic sync_a;
   logic sync_b;
   logic [CW-1:0] cnt;
   wire differs = (sync_b != level);
   wire settle = differs && (cnt == CW'(STABLE - 1));

   initial begin
      if (STABLE < 1) $error("glitch_filter: STABLE must be at least 1");
   end

   // two-stage synchroniser, first stage read only by the second
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= IDLE_LEVEL;
         sync_b <= IDLE_LEVEL;
      end else if (clk_en) begin
         sync_a <= raw;
         sync_b <= sync_a;
      end
   end

   // a level must differ for STABLE cycles before it is taken
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         level <= IDLE_LEVEL;
      end else if (clk_en) begin
         cnt <= (differs && !settle) ? cnt + CW'(1) : '0;
         if (settle) begin
            level <= sync_b;
         end
      end
   end

   chk_spike_hold: assert property (
      @(posedge clock) disable iff (!rst_n)
      (clk_en && $changed(level) && $past(clk_en) && $past(clk_en, 2)
         && $past(clk_en, 3) && STABLE >= 3)
      |-> ($past(differs) && $past(differs, 2) && $past(differs, 3)))
      else $error("filtered level changed before spike window elapsed");

endmodule : glitch_filter

`default_nettype wire

// File: serial_switch_matrix_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "serial_switch_defs.svh"

// Behaviour
// - data bits shift into eight-bit register
// - follows serial clock up to 400 kbit/s
// - reset clears control word, switches off
// - high strap gives address bit one
// - low strap gives address bit zero
// - read returns exactly one control byte
// - data line only pulled low or released
// - spikes under 50 ns are ignored
// - upper five address bits fixed per variant
// - one bit per switch, msb first
// - control word zero until valid write
// - every written byte updates the switches
module serial_switch_matrix_ctrl #(
   parameter logic [4:0] VARIANT_UPPER = `SSM_UPPER_EIGHT
) (
   // clock, reset, enable
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   // two-wire bus pins
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // address straps
   input wire logic ADDR_STRAP_BIT0,
   input wire logic ADDR_STRAP_BIT1,
   // switch enables, bit 7 is switch eight, bit 0 switch one
   output logic [7:0] SWITCH_ENABLE
);
   import serial_switch_pkg::*;

   initial begin
      if (VARIANT_UPPER != `SSM_UPPER_EIGHT
          && VARIANT_UPPER != `SSM_UPPER_DUAL) begin
         $error("serial_switch_matrix_ctrl: unknown VARIANT_UPPER");
      end
      if (`SSM_MAX_KBPS * 2 * 1000 * `SSM_SPIKE_CYCLES * 4
          > `SSM_CLOCK_MHZ * 1000000) begin
         $error("serial_switch_matrix_ctrl: clock too slow for the link");
      end
   end

   bus_level_t now;
   bus_level_t prev;
   pin_drive_t drive;
   state_t state;
   state_t next_state;
   logic [2:0] bit_cnt;
   logic byte_done;
   logic rw;
   logic [7:0] shift;
   logic [7:0] tx;
   logic [7:0] ctrl;
   logic strap0_a;
   logic strap0_b;
   logic strap1_a;
   logic strap1_b;

   // spike filters on both bus lines, each with its own synchroniser
   glitch_filter #(.STABLE(`SSM_SPIKE_CYCLES), .IDLE_LEVEL(1'b1)) u_scl (
      .clock(CLOCK),
      .rst_n(RST_N),
      .clk_en(CLK_EN),
      .raw(SCL_IN),
      .level(now.scl)
   );
   glitch_filter #(.STABLE(`SSM_SPIKE_CYCLES), .IDLE_LEVEL(1'b1)) u_sda (
      .clock(CLOCK),
      .rst_n(RST_N),
      .clk_en(CLK_EN),
      .raw(SDA_IN),
      .level(now.sda)
   );

   // strap synchronisers; the first stage feeds only the second
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         strap0_a <= 1'b0;
         strap0_b <= 1'b0;
         strap1_a <= 1'b0;
         strap1_b <= 1'b0;
      end else if (CLK_EN) begin
         strap0_a <= ADDR_STRAP_BIT0;
         strap0_b <= strap0_a;
         strap1_a <= ADDR_STRAP_BIT1;
         strap1_b <= strap1_a;
      end
   end

   // bus events and address decode
   wire scl_rise = now.scl && !prev.scl;
   wire scl_fall = !now.scl && prev.scl;
   wire start_seen = prev.scl && now.scl && prev.sda && !now.sda;
   wire stop_seen = prev.scl && now.scl && !prev.sda && now.sda;
   wire [7:0] rx_byte = {shift[6:0], now.sda};
   wire [6:0] own_addr =
      {VARIANT_UPPER, strap1_b, strap0_b};
   wire addr_match =
      (shift[`SSM_ADDR_MSB:`SSM_ADDR_LSB] == own_addr);
   wire byte_end = scl_fall && byte_done;

   // next-state selection
   always_comb begin
      next_state = state;
      if (start_seen) begin
         next_state = ST_ADDR;
      end else if (stop_seen) begin
         next_state = ST_IDLE;
      end else if (scl_fall) begin
         case (state)
            ST_ADDR: begin
               if (byte_done) begin
                  next_state = addr_match ? ST_ADDR_ACK : ST_IDLE;
               end
            end
            ST_ADDR_ACK: next_state = rw ? ST_READ : ST_WRITE;
            ST_WRITE: begin
               if (byte_done) begin
                  next_state = ST_WRITE_ACK;
               end
            end
            ST_WRITE_ACK: next_state = ST_WRITE;
            ST_READ: begin
               if (byte_done) begin
                  next_state = ST_READ_ACK;
               end
            end
            ST_READ_ACK: next_state = ST_IDLE;
            default: next_state = state;
         endcase
      end
   end

   // previous filtered levels and state register
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         prev <= '{scl: 1'b1, sda: 1'b1};
         state <= ST_IDLE;
      end else if (CLK_EN) begin
         prev <= now;
         state <= next_state;
      end
   end

   // bit counting and input shifting on rising serial clock
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         bit_cnt <= 3'h0;
         byte_done <= 1'b0;
         shift <= 8'h00;
      end else if (CLK_EN) begin
         if (start_seen || (scl_fall && byte_done)) begin
            bit_cnt <= 3'h0;
            byte_done <= 1'b0;
         end else if (scl_rise && (state == ST_ADDR || state == ST_WRITE
                                   || state == ST_READ)) begin
            shift <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
            byte_done <= (bit_cnt == `SSM_LAST_BIT);
         end
      end
   end

   // direction bit, control word and read shifter
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rw <= 1'b0;
         ctrl <= `SSM_CTRL_RESET;
         tx <= 8'h00;
      end else if (CLK_EN) begin
         if (byte_end && state == ST_ADDR) begin
            rw <= shift[`SSM_RW_BIT];
         end
         if (byte_end && state == ST_WRITE) begin
            ctrl <= shift;
         end
         if (scl_fall && state == ST_ADDR_ACK) begin
            tx <= {ctrl[6:0], 1'b0};
         end else if (scl_fall && state == ST_READ && !byte_done) begin
            tx <= {tx[6:0], 1'b0};
         end
      end
   end

   // open-drain data drive: only ever low or released
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         drive <= '{out: 1'b0, oe: 1'b0};
      end else if (CLK_EN) begin
         drive.out <= 1'b0;
         if (start_seen || stop_seen) begin
            drive.oe <= 1'b0;
         end else if (scl_fall) begin
            case (state)
               // ack only our own address
               ST_ADDR: drive.oe <= byte_done && addr_match;
               ST_ADDR_ACK: drive.oe <= rw && !ctrl[7];
               ST_WRITE: drive.oe <= byte_done;
               ST_READ: drive.oe <= !byte_done && !tx[7];
               default: drive.oe <= 1'b0;
            endcase
         end
      end
   end

   // outputs straight from flip-flops
   assign SDA_OUT = drive.out;
   assign SDA_OE = drive.oe;
   assign SWITCH_ENABLE = ctrl;

   chk_reset_clears: assert property (
      @(posedge CLOCK) $rose(RST_N) |-> (SWITCH_ENABLE == 8'h00 && !SDA_OE))
      else $error("switches not off after reset");

   chk_addr_ack_drive: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && byte_end && state == ST_ADDR && addr_match)
      |=> (SDA_OE && !SDA_OUT && state == ST_ADDR_ACK))
      else $error("own address not acknowledged");

   chk_foreign_release: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && byte_end && state == ST_ADDR && !start_seen && !stop_seen
       && shift[7:1] != {VARIANT_UPPER, strap1_b, strap0_b})
      |=> (!SDA_OE && state == ST_IDLE))
      else $error("foreign address not ignored");

   chk_write_update: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && byte_end && state == ST_WRITE)
      |=> (SWITCH_ENABLE == $past(shift) && SDA_OE))
      else $error("write byte did not update switches");

   chk_read_first_bit: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && scl_fall && state == ST_ADDR_ACK && rw && !start_seen
       && !stop_seen)
      |=> (SDA_OE == !SWITCH_ENABLE[7]))
      else $error("read did not start with control word top bit");

   chk_read_one_byte: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      (CLK_EN && scl_fall && state == ST_READ_ACK)
      |=> (state == ST_IDLE) ##1 !SDA_OE)
      else $error("more than one byte returned on read");

   chk_drive_low_only: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      SDA_OE |-> !SDA_OUT)
      else $error("data line driven high");

   chk_word_stable: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      $changed(SWITCH_ENABLE) |-> $past(byte_end && state == ST_WRITE))
      else $error("control word changed without a completed write");

endmodule : serial_switch_matrix_ctrl

`default_nettype wire

// File: bus_master_model.sv
`timescale 1ns/10ps
`default_nettype none

module bus_master_model #(
   parameter int HALF = 63
) (
   // clock
   input wire logic clock,
   // bus lines
   output logic scl,
   output logic pull_low,
   input wire logic sda
);
   // lines released and clock high while idle
   initial begin
      scl = 1'b1;
      pull_low = 1'b0;
   end

   // HALF cycles of 20 ns high and low keeps the clock below 400 kHz
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick

   // start or repeated start: data falls while clock high
   task automatic start();
      tick(4);
      pull_low <= 1'b0;
      tick(HALF / 2);
      scl <= 1'b1;
      tick(HALF);
      pull_low <= 1'b1;
      tick(HALF);
      scl <= 1'b0;
   endtask : start

   // stop: data rises while clock high
   task automatic stop();
      tick(4);
      pull_low <= 1'b1;
      tick(HALF / 2);
      scl <= 1'b1;
      tick(HALF);
      pull_low <= 1'b0;
      tick(HALF);
   endtask : stop

   // one bit; the line is only pulled low or released
   // spike adds 40 ns pulses on both lines that must be ignored
   task automatic bit_io(input logic b, input bit spike, output logic got);
      tick(4);
      pull_low <= ~b;
      tick(HALF / 2);
      if (spike) begin
         scl <= 1'b1;
         tick(2);
         scl <= 1'b0;
      end
      tick(HALF / 2);
      scl <= 1'b1;
      tick(HALF / 2);
      got = sda;
      if (spike) begin
         pull_low <= b;
         tick(2);
         pull_low <= ~b;
      end
      tick(HALF / 2);
      scl <= 1'b0;
   endtask : bit_io

   // eight bits msb first, then the ninth clock for acknowledge
   task automatic xfer(input logic [7:0] out_b, input logic ack_out,
         input bit spike, output logic [7:0] in_b, output logic acked);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_io(out_b[i], spike, g);
         in_b[i] = g;
      end
      bit_io(ack_out, 1'b0, g);
      acked = ~g;
   endtask : xfer
endmodule : bus_master_model

`default_nettype wire

// File: serial_switch_matrix_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module serial_switch_matrix_ctrl_tb_top;
   logic clock, rst_n, strap0, strap1, scl, pull_low, sda_wire;
   logic sda_out, sda_oe, dual_out, dual_oe, ack;
   logic clk_en;
   logic [7:0] sw, dual_sw, rd;
   int bad_count = 0;
   int n_checks = 0;

   // open-drain data line with pull-up, both devices on one bus
   assign sda_wire = ~(pull_low | (sda_oe & ~sda_out) | (dual_oe & ~dual_out));

   // system clock, 20 ns period
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   bus_master_model m (.clock(clock), .scl(scl), .pull_low(pull_low),
      .sda(sda_wire));
   serial_switch_matrix_ctrl dut (.CLOCK(clock), .RST_N(rst_n),
      .CLK_EN(clk_en), .SCL_IN(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out),
      .SDA_OE(sda_oe), .ADDR_STRAP_BIT0(strap0), .ADDR_STRAP_BIT1(strap1),
      .SWITCH_ENABLE(sw));
   serial_switch_matrix_ctrl #(.VARIANT_UPPER(5'h11)) dut_dual (
      .CLOCK(clock), .RST_N(rst_n), .CLK_EN(clk_en), .SCL_IN(scl),
      .SDA_IN(sda_wire), .SDA_OUT(dual_out), .SDA_OE(dual_oe),
      .ADDR_STRAP_BIT0(strap0), .ADDR_STRAP_BIT1(strap1),
      .SWITCH_ENABLE(dual_sw));

   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   // address byte from the fixed upper bits and the straps
   function automatic logic [7:0] addr(input logic [4:0] up, input logic rw);
      return {up, strap1, strap0, rw};
   endfunction : addr

   // addressed write of one byte, switches left for the caller to check
   task automatic put(input logic [7:0] a, input logic [7:0] d, input bit sp);
      m.start();
      m.xfer(a, 1'b1, 1'b0, rd, ack);
      m.xfer(d, 1'b1, sp, rd, ack);
      m.stop();
   endtask : put

   task automatic test_reset();
      check(sw, 8'h00);
      check({7'h0, sda_oe}, 8'h00);
      $display("test reset done");
   endtask : test_reset

   // every strap setting, two bytes in one transfer
   task automatic test_write();
      for (int s = 0; s < 4; s++) begin
         @(posedge clock);
         strap0 <= s[0];
         strap1 <= s[1];
         m.tick(6);
         m.start();
         m.xfer(addr(5'h13, 1'b0), 1'b1, 1'b0, rd, ack);
         check({7'h0, ack}, 8'h01);
         m.xfer(8'h81 ^ s[7:0], 1'b1, 1'b0, rd, ack);
         check({7'h0, ack}, 8'h01);
         check(sw, 8'h81 ^ s[7:0]);
         m.xfer(8'h3c + s[7:0], 1'b1, 1'b0, rd, ack);
         check(sw, 8'h3c + s[7:0]);
         m.stop();
         check(dual_sw, 8'h00);
      end
      $display("test write done");
   endtask : test_write

   // other variant answers its own address, wrong straps are ignored
   task automatic test_foreign();
      put(addr(5'h11, 1'b0), 8'h5a, 1'b0);
      check(dual_sw, 8'h5a);
      check(sw, 8'h3f);
      m.start();
      m.xfer({5'h13, ~strap1, ~strap0, 1'b0}, 1'b1, 1'b0, rd, ack);
      check({7'h0, ack}, 8'h00);
      m.xfer(8'h00, 1'b1, 1'b0, rd, ack);
      check({7'h0, ack}, 8'h00);
      m.stop();
      check(sw, 8'h3f);
      $display("test foreign done");
   endtask : test_foreign

   // one byte read back, further clocks see a released line
   task automatic test_read();
      m.start();
      m.xfer(addr(5'h13, 1'b1), 1'b1, 1'b0, rd, ack);
      check({7'h0, ack}, 8'h01);
      m.xfer(8'hff, 1'b0, 1'b0, rd, ack);
      check(rd, 8'h3f);
      m.xfer(8'hff, 1'b1, 1'b0, rd, ack);
      check(rd, 8'hff);
      m.stop();
      check(sw, 8'h3f);
      $display("test read done");
   endtask : test_read

   // short pulses on both lines during a write
   task automatic test_spike();
      put(addr(5'h13, 1'b0), 8'h96, 1'b1);
      check(sw, 8'h96);
      $display("test spike done");
   endtask : test_spike

   // clock enable low: a whole write goes unseen and unanswered
   task automatic test_freeze();
      @(posedge clock);
      clk_en <= 1'b0;
      put(addr(5'h13, 1'b0), 8'h24, 1'b0);
      check({7'h0, ack}, 8'h00);
      check(sw, 8'h96);
      @(posedge clock);
      clk_en <= 1'b1;
      m.tick(10);
      check(sw, 8'h96);
      $display("test freeze done");
   endtask : test_freeze

   // reset in mid-run clears at once, without a clock edge
   task automatic test_reset_mid();
      @(posedge clock);
      rst_n <= 1'b0;
      #5;
      check(sw, 8'h00);
      check(dual_sw, 8'h00);
      @(posedge clock);
      rst_n <= 1'b1;
      m.tick(10);
      check(sw, 8'h00);
      $display("test reset_mid done");
   endtask : test_reset_mid

   // bound on the whole run
   initial begin
      repeat (90000) @(posedge clock);
      bad_count++;
      $display("unexpected at %0t: run did not finish", $time);
      end_of_test();
   end

   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      strap0 = 1'b0;
      strap1 = 1'b0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      m.tick(10);
      test_reset();
      test_write();
      test_foreign();
      test_read();
      test_spike();
      test_freeze();
      test_reset_mid();
      end_of_test();
   end
endmodule : serial_switch_matrix_ctrl_tb_top

`default_nettype wire
